// *** logic/asp_fifo.sv ***
`timescale 1ns/1ns
module asp_fifo #(
    parameter int WIDTH = 30,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_r;
    logic [AW-1:0]    rd_r;
    logic [AW:0]      cnt_r;
    logic [AW:0]      cnt_nxt;
    logic             push;
    logic             pop;

    assign cnt_nxt   = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rd_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
            in_ready <= 1'b1;
        end else begin
            if (push) begin
                wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
            end
            cnt_r <= cnt_nxt;
            in_ready <= (cnt_nxt != (AW+1)'(DEPTH));
        end
    end
endmodule // asp_fifo

// *** logic/asp_pkg.sv ***
package asp_pkg;

    // ----------------------------------------------------------------
    // Frame layout
    // ----------------------------------------------------------------
    localparam int FRAME_BITS      = 32;
    localparam int CFG_BITS        = 13;
    localparam int PREFIX_BITS     = 3;
    localparam int ADDR_BITS       = 5;
    localparam int SPEED_BITS      = 5;
    localparam int RESULT_BITS     = 30;

    localparam logic [2:0] PREFIX_UPDATE = 3'h5;
    localparam logic [2:0] PREFIX_KEEP_A = 3'h0;
    localparam logic [2:0] PREFIX_KEEP_B = 3'h4;

    // ----------------------------------------------------------------
    // Reset selections and timing
    // ----------------------------------------------------------------
    localparam logic [4:0] ADDR_RST       = 5'h00;
    localparam logic [4:0] SPEED_RST      = 5'h01;
    localparam logic [4:0] SPEED_KEEP     = 5'h00;
    localparam int         CLK_MHZ        = 250;
    localparam int         SCK_HALF_NS    = 16;
    localparam int         SCK_HALF_CYC   = (SCK_HALF_NS * CLK_MHZ) / 1000;
    localparam int         CONV_CYC_DEF   = 1000;

    // Channel and reference address, bit order as shifted in
    typedef struct packed {
        logic single_ended_select;
        logic polarity_swap;
        logic global_ref_select;
        logic pair_addr_hi;
        logic pair_addr_lo;
    } asp_addr_t;

    typedef struct packed {
        asp_addr_t  addr;
        logic [4:0] speed;
    } asp_cfg_t;

    // Decoded input routing
    typedef struct packed {
        logic [3:0] pos_sel;
        logic [3:0] neg_sel;
        logic [2:0] ref_sel;
    } asp_route_t;

    typedef enum logic [3:0] {
        ST_CONV  = 4'b0001,
        ST_SLEEP = 4'b0010,
        ST_DOUT  = 4'b0100,
        ST_IDLE  = 4'b1000
    } asp_state_t;

endpackage

// *** logic/asp_serial_port.sv ***
`timescale 1ns/1ns
module asp_serial_port
    import asp_pkg::*;
#(
    parameter int CONV_CYC  = CONV_CYC_DEF,
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic                   clk_sys,
    input  wire logic                   srst,
    input  wire logic                   clock_source_select,
    input  wire logic                   cs_n,
    input  wire logic                   sck_in,
    output logic                        sck_out,
    output logic                        sck_oe_n,
    input  wire logic                   sdi,
    output logic                        sdo_out,
    output logic                        sdo_oe_n,
    input  wire logic                   result_valid,
    output logic                        result_ready,
    input  wire logic [RESULT_BITS-1:0] result_data,
    output asp_cfg_t                    cfg_active,
    output asp_route_t                  route_active,
    output logic                        conv_busy,
    output logic                        conv_start
);
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] cs_s_r;
    logic [1:0] sck_s_r;
    logic [1:0] sdi_s_r;
    logic [1:0] ext_s_r;
    logic       cs_d_r;
    logic       sck_d_r;
    logic       int_mode;
    logic       sck_eff;
    logic       sck_rise;
    logic       sck_fall;
    logic       cs_rise;
    logic       cs_low;
    logic [7:0] div_r;
    logic       int_sck_r;
    asp_state_t state_r;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cs_s_r  <= 2'h3;
            sck_s_r <= 2'h0;
            sdi_s_r <= 2'h0;
            ext_s_r <= 2'h0;
            cs_d_r  <= 1'b1;
            sck_d_r <= 1'b0;
        end else begin
            cs_s_r  <= {cs_s_r[0], cs_n};
            sck_s_r <= {sck_s_r[0], sck_in};
            sdi_s_r <= {sdi_s_r[0], sdi};
            ext_s_r <= {ext_s_r[0], clock_source_select};
            cs_d_r  <= cs_s_r[1];
            sck_d_r <= sck_eff;
        end
    end

    // ----------------------------------------------------------------
    // Edge detection
    // ----------------------------------------------------------------
    // SCK is ignored while CS is high, so edges count only when selected
    assign int_mode = ext_s_r[1];
    assign cs_low   = ~cs_s_r[1];
    assign sck_eff  = int_mode ? int_sck_r : sck_s_r[1];
    assign sck_rise = sck_eff & ~sck_d_r & cs_low;
    assign sck_fall = ~sck_eff & sck_d_r & cs_low;
    assign cs_rise  = cs_s_r[1] & ~cs_d_r;

    // ----------------------------------------------------------------
    // Internal clock generator
    // ----------------------------------------------------------------
    // Runs only while a frame may move, so the host sees no stray edges
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            div_r     <= '0;
            int_sck_r <= 1'b0;
        end else if (int_mode && cs_low && state_r != ST_CONV) begin
            if (div_r == 8'(SCK_HALF_CYC - 1)) begin
                div_r     <= '0;
                int_sck_r <= ~int_sck_r;
            end else begin
                div_r <= div_r + 8'h01;
            end
        end else begin
            div_r     <= '0;
            int_sck_r <= 1'b0;
        end
    end

    // Registered so a divider glitch never reaches the pin
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sck_out  <= 1'b0;
            sck_oe_n <= 1'b1;
        end else begin
            sck_out  <= int_sck_r;
            sck_oe_n <= ~int_mode;
        end
    end

    // ----------------------------------------------------------------
    // Conversion sequencer
    // ----------------------------------------------------------------
    logic [31:0]            conv_cnt_r;
    logic [5:0]             bit_cnt_r;
    logic [FRAME_BITS-1:0]  shift_r;
    logic [RESULT_BITS-1:0] last_result_r;
    logic                   frame_end;
    logic                   conv_done;

    assign frame_end = (state_r == ST_DOUT) && sck_fall
                       && (bit_cnt_r == 6'(FRAME_BITS - 1));
    assign conv_done = (state_r == ST_CONV) && (conv_cnt_r == 32'(CONV_CYC - 1));

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_r <= ST_CONV;
        end else begin
            case (state_r)
                ST_CONV: begin
                    if (conv_done) begin
                        state_r <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (sck_rise) begin
                        state_r <= ST_DOUT;
                    end
                end
                ST_DOUT: begin
                    if (cs_rise || frame_end) begin
                        state_r <= ST_CONV;
                    end
                end
                default: begin
                    state_r <= ST_CONV;
                end
            endcase
        end
    end

    // Counts only inside a conversion, so every conversion starts from zero
    always_ff @(posedge clk_sys) begin
        if (srst || state_r != ST_CONV) begin
            conv_cnt_r <= '0;
        end else begin
            conv_cnt_r <= conv_cnt_r + 32'h0000_0001;
        end
    end

    // ----------------------------------------------------------------
    // Status outputs
    // ----------------------------------------------------------------
    // The start pulse marks the edge where new selections go live
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            conv_start <= 1'b1;
            conv_busy  <= 1'b1;
        end else begin
            conv_start <= (state_r == ST_DOUT) && (cs_rise || frame_end);
            conv_busy  <= (state_r == ST_CONV) && !conv_done;
        end
    end

    // ----------------------------------------------------------------
    // Result intake from the converter core through the FIFO
    // ----------------------------------------------------------------
    logic                   fifo_valid;
    logic [RESULT_BITS-1:0] fifo_data;
    logic                   fifo_ready;

    // The oldest queued result is taken; one entry drains on each finished conversion
    assign fifo_ready = conv_done;

    asp_fifo #(
        .WIDTH (RESULT_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .in_valid  (result_valid),
        .in_ready  (result_ready),
        .in_data   (result_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready),
        .out_data  (fifo_data)
    );

    // ----------------------------------------------------------------
    // Result capture
    // ----------------------------------------------------------------
    // Core supplies {sign, 24-bit result, 5 sub steps} already coded
    // Without a fresh result the previous one repeats
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            last_result_r <= '0;
        end else if (conv_done && fifo_valid) begin
            last_result_r <= fifo_data;
        end
    end

    // ----------------------------------------------------------------
    // Output shifter
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            shift_r   <= '0;
            bit_cnt_r <= '0;
        end else if (state_r == ST_SLEEP) begin
            // Frame head is the done flag low, then the dummy bit low
            shift_r   <= {1'b0, 1'b0, last_result_r};
            bit_cnt_r <= '0;
        end else if (state_r == ST_DOUT && sck_fall) begin
            shift_r   <= {shift_r[FRAME_BITS-2:0], 1'b0};
            bit_cnt_r <= bit_cnt_r + 6'h01;
        end
    end

    // ----------------------------------------------------------------
    // Data output driver
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sdo_out  <= 1'b1;
            sdo_oe_n <= 1'b1;
        end else begin
            sdo_oe_n <= ~cs_low;
            case (state_r)
                ST_CONV:  sdo_out <= 1'b1;
                ST_SLEEP: sdo_out <= 1'b0;
                ST_DOUT:  sdo_out <= shift_r[FRAME_BITS-1];
                default:  sdo_out <= 1'b1;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Configuration receiver
    // ----------------------------------------------------------------
    logic [CFG_BITS-1:0] cfg_sh_r;
    logic [3:0]          cfg_cnt_r;
    asp_cfg_t            cfg_r;
    logic [2:0]          prefix;
    asp_cfg_t            rx_cfg;

    assign prefix = cfg_sh_r[CFG_BITS-1 -: PREFIX_BITS];
    assign rx_cfg = cfg_sh_r[ADDR_BITS+SPEED_BITS-1:0];

    // Bits sampled on rising SCK; the frame's first rise is the wake edge
    // The count stops at thirteen so late bits cannot touch the word
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cfg_sh_r  <= '0;
            cfg_cnt_r <= '0;
        end else if (state_r == ST_SLEEP && !sck_rise) begin
            cfg_cnt_r <= '0;
        end else if ((state_r == ST_SLEEP || state_r == ST_DOUT) && sck_rise
                     && cfg_cnt_r != 4'(CFG_BITS)) begin
            cfg_sh_r  <= {cfg_sh_r[CFG_BITS-2:0], sdi_s_r[1]};
            cfg_cnt_r <= cfg_cnt_r + 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // Configuration apply
    // ----------------------------------------------------------------
    // Selections take effect at the start of the next conversion
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cfg_r <= {ADDR_RST, SPEED_RST};
        end else if (state_r == ST_DOUT && (cs_rise || frame_end)
                     && cfg_cnt_r == 4'(CFG_BITS)
                     && prefix == PREFIX_UPDATE) begin
            cfg_r.addr <= rx_cfg.addr;
            if (rx_cfg.speed != SPEED_KEEP) begin
                cfg_r.speed <= rx_cfg.speed;
            end
        end
    end

    // ----------------------------------------------------------------
    // Input and reference routing
    // ----------------------------------------------------------------
    logic [1:0] pair;
    logic [3:0] even_ch;
    logic [3:0] odd_ch;

    assign pair    = {cfg_r.addr.pair_addr_hi, cfg_r.addr.pair_addr_lo};
    assign even_ch = {1'b0, pair, 1'b0};
    assign odd_ch  = {1'b0, pair, 1'b1};

    // Code 8 on a select stands for the common negative input
    // Differential and single-ended share the positive pick
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            route_active <= '{pos_sel: 4'h0, neg_sel: 4'h1, ref_sel: 3'h0};
            cfg_active   <= {ADDR_RST, SPEED_RST};
        end else begin
            cfg_active <= cfg_r;
            if (cfg_r.addr.single_ended_select) begin
                route_active.pos_sel <= cfg_r.addr.polarity_swap ? odd_ch : even_ch;
                route_active.neg_sel <= 4'h8;
            end else begin
                route_active.pos_sel <= cfg_r.addr.polarity_swap ? odd_ch : even_ch;
                route_active.neg_sel <= cfg_r.addr.polarity_swap ? even_ch : odd_ch;
            end
            route_active.ref_sel <= cfg_r.addr.global_ref_select ? 3'h4 : {1'b0, pair};
        end
    end
endmodule // asp_serial_port

// *** tb/asp_host_model.sv ***
`timescale 1ns/1ns
module asp_host_model (
    input  wire logic clk_sys,
    input  wire logic sck_out,
    input  wire logic sck_oe_n,
    input  wire logic sdo_out,
    input  wire logic sdo_oe_n,
    output logic      cs_n,
    output logic      sck_line,
    output logic      sdi
);
    // ----------------------------------------------------------------
    // Host side of the serial link
    // ----------------------------------------------------------------
    logic sck_h = 1'b0;
    initial cs_n = 1'b1;
    initial sdi = 1'b0;
    // Wire level of the shared clock pin
    assign sck_line = sck_oe_n ? sck_h : sck_out;
    // Deselected, sdi means nothing, so keep it moving
    always @(negedge clk_sys) begin
        if (cs_n)
            sdi <= ~sdi;
    end
    task automatic sel(input logic v);
        @(negedge clk_sys);
        cs_n = v;
        @(negedge clk_sys);
        if (!v)
            sdi = 1'b0;
    endtask
    task automatic frame(input logic [12:0] cfg, input int npulse, output logic [31:0] rx);
        rx = 32'h0000_0000;
        sel(1'b0);
        for (int i = 0; i < 400 && {sdo_oe_n, sdo_out} !== 2'h0; i++)
            @(negedge clk_sys);
        for (int k = 0; k < npulse; k++) begin
            sdi = (k < 13) ? cfg[12-k] : ~sdi;
            repeat (4) @(negedge clk_sys);
            sck_h = 1'b1;
            repeat (4) @(negedge clk_sys);
            rx[31-k] = sdo_out;
            sck_h = 1'b0;
        end
        repeat (4) @(negedge clk_sys);
        sel(1'b1);
    endtask
endmodule // asp_host_model

// *** tb/asp_serial_port_bench.sv ***
`timescale 1ns/1ns
module asp_serial_port_bench;
    import asp_pkg::*;
    localparam int CONV = 50;
    logic                   clk_sys, srst, clock_source_select, cs_n, sck_in, sdi;
    logic                   sck_out, sck_oe_n, sdo_out, sdo_oe_n, conv_busy, conv_start;
    logic                   result_valid, result_ready;
    logic [RESULT_BITS-1:0] result_data;
    logic [RESULT_BITS-1:0] words [16];
    logic [31:0]            rx;
    asp_cfg_t               cfg_active, exp_cfg;
    asp_route_t             route_active;
    int                     mismatches, compares, cycles;

    asp_serial_port #(.CONV_CYC(CONV), .FIFO_DEPTH(16)) dut (
        .clk_sys(clk_sys), .srst(srst), .clock_source_select(clock_source_select),
        .cs_n(cs_n), .sck_in(sck_in), .sck_out(sck_out), .sck_oe_n(sck_oe_n), .sdi(sdi),
        .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .result_valid(result_valid),
        .result_ready(result_ready), .result_data(result_data), .cfg_active(cfg_active),
        .route_active(route_active), .conv_busy(conv_busy), .conv_start(conv_start));
    asp_host_model host (
        .clk_sys(clk_sys), .sck_out(sck_out), .sck_oe_n(sck_oe_n), .sdo_out(sdo_out),
        .sdo_oe_n(sdo_oe_n), .cs_n(cs_n), .sck_line(sck_in), .sdi(sdi));

    // ----------------------------------------------------------------
    // Checking helpers
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic asp_route_t exp_route(asp_addr_t a);
        logic [1:0] p;
        p = {a.pair_addr_hi, a.pair_addr_lo};
        return '{{1'b0, p, a.polarity_swap}, a.single_ended_select ? 4'h8
                 : {1'b0, p, ~a.polarity_swap}, a.global_ref_select ? 3'h4 : {1'b0, p}};
    endfunction
    task automatic check_sel();
        repeat (8) @(negedge clk_sys);
        check("cfg", 32'(cfg_active), 32'(exp_cfg));
        check("route", 32'(route_active), 32'(exp_route(exp_cfg.addr)));
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_fill();
        check_sel();
        for (int i = 0; i < 16; i++) begin
            result_valid = 1'b1;
            result_data  = words[i];
            @(negedge clk_sys);
        end
        result_valid = 1'b0;
        check("full_ready", 32'(result_ready), 32'h0000_0000);
        $display("test fill done");
    endtask
    task automatic t_eoc();
        host.sel(1'b0);
        repeat (6) @(negedge clk_sys);
        check("eoc_busy", 32'({sdo_oe_n, sdo_out}), 32'h0000_0001);
        for (int i = 0; i < CONV && sdo_out !== 1'b0; i++)
            @(negedge clk_sys);
        check("eoc_done", 32'(sdo_out), 32'h0000_0000);
        host.sel(1'b1);
        repeat (6) @(negedge clk_sys);
        check("sdo_released", 32'(sdo_oe_n), 32'h0000_0001);
        $display("test eoc done");
    endtask
    task automatic t_frames();
        logic [12:0] c;
        for (int i = 0; i < 16; i++) begin
            c[12:10] = (i % 4 == 1) ? PREFIX_KEEP_A : (i % 4 == 3) ? PREFIX_KEEP_B : PREFIX_UPDATE;
            c[9:5]   = 5'(i * 7);
            c[4:0]   = (i % 3 == 0) ? SPEED_KEEP : 5'(i + 2);
            host.frame(c, 32, rx);
            check("frame", rx, {2'b00, words[i]});
            if (c[12:10] == PREFIX_UPDATE) begin
                exp_cfg.addr = asp_addr_t'(c[9:5]);
                if (c[4:0] != SPEED_KEEP)
                    exp_cfg.speed = c[4:0];
            end
            check_sel();
        end
        $display("test frames done");
    endtask
    task automatic t_abort();
        int n;
        host.frame(13'h1_7FF, 8, rx);
        for (n = 0; n < 20 && conv_start !== 1'b1; n++)
            @(negedge clk_sys);
        check("abort_start", 32'(n < 20), 32'h0000_0001);
        check_sel();
        host.frame(13'h0_000, 32, rx);
        check("repeat_result", rx, {2'b00, words[15]});
        $display("test abort done");
    endtask
    task automatic t_internal();
        int   n;
        logic last;
        n = 0;
        last = 1'b0;
        clock_source_select = 1'b1;
        host.sel(1'b0);
        repeat (8) @(negedge clk_sys);
        check("sck_drive", 32'(sck_oe_n), 32'h0000_0000);
        for (int i = 0; i < 2000 && conv_start !== 1'b1; i++) begin
            if (sck_out === 1'b1 && last === 1'b0)
                n++;
            last = sck_out;
            @(negedge clk_sys);
        end
        host.sel(1'b1);
        clock_source_select = 1'b0;
        check("sck_pulses", 32'(n), 32'h0000_0020);
        $display("test internal done");
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // Whole run is near 6000 cycles; the ceiling leaves ample margin
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            mismatches++;
            wrap_up();
        end
    end
    initial begin
        srst = 1'b1;
        clock_source_select = 1'b0;
        result_valid = 1'b0;
        result_data = 30'h0000_0000;
        mismatches = 0;
        compares = 0;
        cycles = 0;
        exp_cfg = {ADDR_RST, SPEED_RST};
        words[0] = 30'h3000_0000;
        words[1] = 30'h2000_0000;
        words[2] = 30'h1FFF_FFFF;
        words[3] = 30'h0FFF_FFFF;
        for (int i = 4; i < 16; i++)
            words[i] = 30'(i * 32'h0135_79BD);
        repeat (2) @(negedge clk_sys);
        srst = 1'b0;
        t_fill();
        t_eoc();
        t_frames();
        t_abort();
        t_internal();
        wrap_up();
    end
endmodule // asp_serial_port_bench

// *** tb/asp_serial_port_sva.sv ***
`timescale 1ns/1ns
module asp_serial_port_sva
    import asp_pkg::*;
#(
    parameter int CONV_CYC = CONV_CYC_DEF
) (
    input wire logic       clk_sys,
    input wire logic       srst,
    input wire logic       clock_source_select,
    input wire logic       cs_n,
    input wire logic       sck_oe_n,
    input wire logic       sdo_out,
    input wire logic       sdo_oe_n,
    input wire asp_cfg_t   cfg_active,
    input wire asp_route_t route_active,
    input wire logic       conv_busy,
    input wire logic       conv_start
);
    // ----------------------------------------------------------------
    // Port checks
    // ----------------------------------------------------------------
    int        busy_cnt_r;
    asp_addr_t a;
    assign a = cfg_active.addr;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    // Conversion length is counted, too long to unroll in a property
    always_ff @(posedge clk_sys) begin
        busy_cnt_r <= (srst || !conv_busy) ? 0 : busy_cnt_r + 1;
    end
    a_sdo_hiz_idle: assert property (cs_n [*5] |-> sdo_oe_n)
        else $error("sdo driven while deselected");
    a_sdo_drive_sel: assert property ((!cs_n) [*5] |-> !sdo_oe_n)
        else $error("sdo not driven while selected");
    a_ext_sck_input: assert property ((!clock_source_select) [*5] |-> sck_oe_n)
        else $error("sck driven in host clock mode");
    a_busy_sdo_high: assert property ((conv_busy && !sdo_oe_n) [*6] |-> sdo_out)
        else $error("sdo low during conversion");
    a_done_sdo_low: assert property (($fell(conv_busy) && !sdo_oe_n) ##1 (!sdo_oe_n) [*3]
        |-> !sdo_out)
        else $error("done flag not low after conversion");
    a_start_pulse: assert property (conv_start && !$past(srst) |=> !conv_start)
        else $error("start pulse too long");
    a_start_busy: assert property (conv_start |=> conv_busy [*8])
        else $error("start without conversion");
    a_conv_bounded: assert property (busy_cnt_r <= CONV_CYC + 2)
        else $error("conversion runs too long");
    a_cfg_at_start: assert property ($changed(cfg_active)
        |-> $past(conv_start) || $past(conv_start, 2))
        else $error("selection changed outside conversion start");
    a_ref_route: assert property ($stable(cfg_active) [*2] |-> route_active.ref_sel ==
        (a.global_ref_select ? 3'h4 : {1'b0, a.pair_addr_hi, a.pair_addr_lo}))
        else $error("reference routing wrong");
    a_inputs_route: assert property ($stable(cfg_active) [*2] |-> route_active.pos_sel ==
        {1'b0, a.pair_addr_hi, a.pair_addr_lo, a.polarity_swap} && route_active.neg_sel ==
        (a.single_ended_select ? 4'h8 : {1'b0, a.pair_addr_hi, a.pair_addr_lo,
        ~a.polarity_swap}))
        else $error("input routing wrong");
endmodule // asp_serial_port_sva

bind asp_serial_port asp_serial_port_sva #(.CONV_CYC(CONV_CYC)) u_sva (
    .clk_sys(clk_sys), .srst(srst), .clock_source_select(clock_source_select),
    .cs_n(cs_n), .sck_oe_n(sck_oe_n), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n),
    .cfg_active(cfg_active), .route_active(route_active), .conv_busy(conv_busy),
    .conv_start(conv_start));
